/* src/acs_defs.svh */
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ACS_MODE_OFS 8'h00
`define ACS_TRIG_OFS 8'h04
`define ACS_CHAN_OFS 8'h08
`define ACS_CTRL_OFS 8'h0C
`define ACS_STAT_OFS 8'h10
`define ACS_RES_OFS 8'h20
`define ACS_RES_END 8'h40
// ----------------------------------------
// field positions
// ----------------------------------------
`define ACS_EN_BIT 0
`define ACS_MODE_LSB 1
`define ACS_LEN_LSB 4
`define ACS_GRP_LSB 8
`define ACS_START_BIT 0
`define ACS_DONE_BIT 0
`define ACS_BUSY_BIT 1
`define ACS_SLOT_LSB 4
`define ACS_RES_LSB 4
// ----------------------------------------
// reset values
// ----------------------------------------
`define ACS_MODE_RST 12'h000
`define ACS_TRIG_RST 32'h0000_0000
`define ACS_CHAN_RST 32'h0000_0000
// ----------------------------------------
// timing counts
// ----------------------------------------
`define ACS_SOC_ACLK 3'h3
`define ACS_EOC_ACLK 3'h2
`define ACS_EOC_PCLK 3'h2
`define ACS_ACLK_DIV 8'h04
`endif

/* src/acs_pkg.sv */
package acs_pkg;
    typedef enum logic [2:0] {
        ACS_IDLE,
        ACS_WAIT,
        ACS_DLY,
        ACS_CONV,
        ACS_FLAG
    } acs_state_t;

    typedef enum logic [1:0] {
        ACS_MODE_SINGLE,
        ACS_MODE_BURST,
        ACS_MODE_RSV2,
        ACS_MODE_RSV3
    } acs_mode_t;

    typedef enum logic [1:0] {
        ACS_GRP_SOFT,
        ACS_GRP_TIMER,
        ACS_GRP_PWM,
        ACS_GRP_RSV
    } acs_grp_t;
endpackage

/* src/acs_mem_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface acs_mem_if;
    logic wr_en;
    logic [2:0] wr_idx;
    logic [15:0] wr_data;
    logic rd_en;
    logic [2:0] rd_idx;
    logic [15:0] rd_data;
    modport ctrl (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data);
    modport mem (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data);
endinterface
`default_nettype wire

/* src/acs_result_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module acs_result_mem #(
    parameter int DEPTH = 8
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // access port
    acs_mem_if.mem port
);
    typedef struct packed {
        logic [DEPTH-1:0][15:0] word;
        logic [15:0] rd;
    } acs_mem_s_t;

    acs_mem_s_t q;
    acs_mem_s_t d;

    always_comb begin
        d = q;
        if (port.wr_en) begin
            d.word[port.wr_idx] = port.wr_data;
        end
        // read data comes from the old word on a same-cycle collision
        if (port.rd_en) begin
            d.rd = q.word[port.rd_idx];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign port.rd_data = q.rd;
endmodule
`default_nettype wire

/* src/acs_top.sv */
`include "acs_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module acs_top #(
    parameter logic [7:0] ACLK_DIV = `ACS_ACLK_DIV,
    parameter int SLOTS = 8
) (
    // clock, reset, enable
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    // axi4-lite write
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // axi4-lite read
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    // hardware trigger events, same clock
    input wire logic [7:0] TIMER_TRIG_I,
    input wire logic [7:0] PWM_TRIG_I,
    // analog converter side
    output logic CONV_BEGIN_O,
    output logic [3:0] CONV_CHANNEL_O,
    input wire logic CONV_END_I,
    input wire logic [11:0] CONV_DATA_I,
    // status
    output logic CONV_DONE_O,
    output logic BUSY_O
);
    typedef struct packed {
        acs_pkg::acs_state_t st;
        logic en;
        acs_pkg::acs_mode_t mode;
        logic [2:0] len;
        acs_pkg::acs_grp_t grp;
        logic [31:0] trg;
        logic [31:0] chn;
        logic start;
        logic done;
        logic [2:0] slot;
        logic [7:0] div;
        logic [2:0] cnt;
        logic soc;
        logic [3:0] ch;
        logic [2:0] end_s;
        logic [11:0] dat_s0;
        logic [11:0] dat_s1;
        logic bvalid;
        logic [1:0] bresp;
        logic rpend;
        logic [7:0] raddr;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } acs_top_s_t;

    acs_top_s_t q;
    acs_top_s_t d;
    acs_mem_if mif ();

    acs_result_mem #(
        .DEPTH(SLOTS)
    ) u_mem (
        .clk_i(REF_CLK_I),
        .rst_n_i(NRST_I),
        .ce_i(CE_I),
        .port(mif.mem)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic trig_hit(input acs_pkg::acs_grp_t grp, input logic [3:0] sel,
                                      input logic [7:0] tmr, input logic [7:0] pwm);
        logic hit;
        hit = 1'b0;
        if (sel[3] == 1'b0) begin
            if (grp == acs_pkg::ACS_GRP_TIMER) begin
                hit = tmr[sel[2:0]];
            end else if (grp == acs_pkg::ACS_GRP_PWM) begin
                hit = pwm[sel[2:0]];
            end
        end
        return hit;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    logic tick;
    logic end_evt;
    logic burst_evt;
    logic slot_evt;
    logic wr_hs;
    logic rd_hs;
    logic [31:0] mode_word;
    logic [31:0] merged;

    assign tick = (q.div == ACLK_DIV - 8'h01);
    assign end_evt = q.end_s[1] & ~q.end_s[2];
    assign wr_hs = S_AXI_AWVALID_I & S_AXI_WVALID_I & ~q.bvalid;
    assign rd_hs = S_AXI_ARVALID_I & ~q.rpend & ~q.rvalid;
    assign mode_word = {20'h0_0000, 2'b00, q.grp, 1'b0, q.len, 1'b0, q.mode, q.en};
    // burst source: selected hardware event or the start bit
    assign burst_evt = q.start | trig_hit(q.grp, q.trg[3:0], TIMER_TRIG_I, PWM_TRIG_I);
    // sequential source: the current slot's own selector, start bit in software group
    assign slot_evt = (q.grp == acs_pkg::ACS_GRP_SOFT) ? q.start :
                      trig_hit(q.grp, q.trg[q.slot*4 +: 4], TIMER_TRIG_I, PWM_TRIG_I);

    always_comb begin
        d = q;
        merged = 32'h0000_0000;
        mif.wr_en = 1'b0;
        mif.wr_idx = q.slot;
        mif.wr_data = {q.dat_s1, 4'h0};
        mif.rd_en = 1'b0;
        mif.rd_idx = S_AXI_ARADDR_I[4:2];
        d.soc = 1'b0;
        // pin inputs pass two flops before use
        d.end_s = {q.end_s[1:0], CONV_END_I};
        d.dat_s0 = CONV_DATA_I;
        d.dat_s1 = q.dat_s0;
        d.div = tick ? 8'h00 : q.div + 8'h01;
        // ----------------------------------------
        // sequencer
        // ----------------------------------------
        case (q.st)
            acs_pkg::ACS_IDLE: begin
                d.slot = 3'h0;
                d.cnt = 3'h0;
                if (q.en) begin
                    if (q.mode == acs_pkg::ACS_MODE_BURST) begin
                        if (burst_evt) begin
                            d.st = acs_pkg::ACS_DLY;
                        end
                    end else if (q.mode == acs_pkg::ACS_MODE_SINGLE && q.start) begin
                        // nonzero length arms the sequential walk
                        d.st = (q.len != 3'h0) ? acs_pkg::ACS_WAIT : acs_pkg::ACS_DLY;
                    end
                end
            end
            acs_pkg::ACS_WAIT: begin
                d.cnt = 3'h0;
                if (slot_evt) begin
                    d.st = acs_pkg::ACS_DLY;
                end
            end
            acs_pkg::ACS_DLY: begin
                if (tick) begin
                    d.cnt = q.cnt + 3'h1;
                    if (q.cnt + 3'h1 == `ACS_SOC_ACLK) begin
                        d.soc = 1'b1;
                        d.ch = q.chn[q.slot*4 +: 4];
                        d.st = acs_pkg::ACS_CONV;
                    end
                end
            end
            acs_pkg::ACS_CONV: begin
                d.cnt = 3'h0;
                if (end_evt) begin
                    // result lands long before the flag
                    mif.wr_en = 1'b1;
                    d.st = acs_pkg::ACS_FLAG;
                end
            end
            acs_pkg::ACS_FLAG: begin
                if (q.cnt < `ACS_EOC_ACLK) begin
                    if (tick) begin
                        d.cnt = q.cnt + 3'h1;
                    end
                end else if (q.cnt < `ACS_EOC_ACLK + `ACS_EOC_PCLK - 3'h1) begin
                    d.cnt = q.cnt + 3'h1;
                end else begin
                    d.done = 1'b1;
                    d.cnt = 3'h0;
                    if (q.slot == q.len || q.mode != acs_pkg::ACS_MODE_BURST && q.len == 3'h0) begin
                        d.st = acs_pkg::ACS_IDLE;
                    end else begin
                        d.slot = q.slot + 3'h1;
                        d.st = (q.mode == acs_pkg::ACS_MODE_BURST) ? acs_pkg::ACS_DLY
                                                                 : acs_pkg::ACS_WAIT;
                    end
                end
            end
            default: begin
                d.st = acs_pkg::ACS_IDLE;
            end
        endcase
        // disabling the converter abandons any sequence in flight
        if (!q.en) begin
            d.st = acs_pkg::ACS_IDLE;
        end
        if (tick) begin
            d.start = 1'b0;
        end
        // ----------------------------------------
        // register writes
        // ----------------------------------------
        if (q.bvalid && S_AXI_BREADY_I) begin
            d.bvalid = 1'b0;
        end
        if (wr_hs) begin
            d.bvalid = 1'b1;
            d.bresp = 2'b00;
            case (S_AXI_AWADDR_I)
                `ACS_MODE_OFS: begin
                    merged = merge(mode_word, S_AXI_WDATA_I, S_AXI_WSTRB_I);
                    d.en = merged[`ACS_EN_BIT];
                    d.mode = acs_pkg::acs_mode_t'(merged[`ACS_MODE_LSB +: 2]);
                    d.len = merged[`ACS_LEN_LSB +: 3];
                    d.grp = acs_pkg::acs_grp_t'(merged[`ACS_GRP_LSB +: 2]);
                end
                `ACS_TRIG_OFS: begin
                    d.trg = merge(q.trg, S_AXI_WDATA_I, S_AXI_WSTRB_I);
                end
                `ACS_CHAN_OFS: begin
                    d.chn = merge(q.chn, S_AXI_WDATA_I, S_AXI_WSTRB_I);
                end
                `ACS_CTRL_OFS: begin
                    if (S_AXI_WSTRB_I[0] && S_AXI_WDATA_I[`ACS_START_BIT]) begin
                        d.start = 1'b1;
                    end
                end
                `ACS_STAT_OFS: begin
                    // a flag raised in this very cycle survives the clear
                    if (S_AXI_WSTRB_I[0] && S_AXI_WDATA_I[`ACS_DONE_BIT] && d.done == q.done) begin
                        d.done = 1'b0;
                    end
                end
                default: begin
                    d.bresp = 2'b10;
                end
            endcase
        end
        // ----------------------------------------
        // register reads, two cycles after address
        // ----------------------------------------
        if (q.rvalid && S_AXI_RREADY_I) begin
            d.rvalid = 1'b0;
        end
        if (rd_hs) begin
            d.rpend = 1'b1;
            d.raddr = S_AXI_ARADDR_I;
            mif.rd_en = 1'b1;
        end
        if (q.rpend) begin
            d.rpend = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = 2'b00;
            d.rdata = 32'h0000_0000;
            if (q.raddr >= `ACS_RES_OFS && q.raddr < `ACS_RES_END && q.raddr[1:0] == 2'b00) begin
                d.rdata = {16'h0000, mif.rd_data};
            end else begin
                case (q.raddr)
                    `ACS_MODE_OFS: d.rdata = mode_word;
                    `ACS_TRIG_OFS: d.rdata = q.trg;
                    `ACS_CHAN_OFS: d.rdata = q.chn;
                    `ACS_CTRL_OFS: d.rdata = {31'h0000_0000, q.start};
                    `ACS_STAT_OFS: begin
                        d.rdata[`ACS_DONE_BIT] = q.done;
                        d.rdata[`ACS_BUSY_BIT] = (q.st != acs_pkg::ACS_IDLE);
                        d.rdata[`ACS_SLOT_LSB +: 3] = q.slot;
                    end
                    default: d.rresp = 2'b10;
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            q <= '0;
            q.st <= acs_pkg::ACS_IDLE;
            q.trg <= `ACS_TRIG_RST;
            q.chn <= `ACS_CHAN_RST;
        end else if (CE_I) begin
            q <= d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign S_AXI_AWREADY_O = wr_hs;
    assign S_AXI_WREADY_O = wr_hs;
    assign S_AXI_BRESP_O = q.bresp;
    assign S_AXI_BVALID_O = q.bvalid;
    assign S_AXI_ARREADY_O = ~q.rpend & ~q.rvalid;
    assign S_AXI_RDATA_O = q.rdata;
    assign S_AXI_RRESP_O = q.rresp;
    assign S_AXI_RVALID_O = q.rvalid;
    assign CONV_BEGIN_O = q.soc;
    assign CONV_CHANNEL_O = q.ch;
    assign CONV_DONE_O = q.done;
    assign BUSY_O = (q.st != acs_pkg::ACS_IDLE);
endmodule
`default_nettype wire

/* test/acs_conv_model.sv */
`timescale 1ns/10ps
`default_nettype none
module acs_conv_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // sequencer side
    input wire logic begin_i,
    input wire logic [3:0] channel_i,
    input wire logic [3:0] dly_i,
    output logic end_o,
    output logic [11:0] data_o
);
    logic [4:0] cnt_q;
    logic [1:0] hold_q;
    logic [3:0] ch_q;
    // ----------------------------------------
    // converter
    // ----------------------------------------
    // data flips outside the end window, so a late sample cannot pass
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 5'h00;
            hold_q <= 2'h0;
            ch_q <= 4'h0;
            end_o <= 1'h0;
            data_o <= 12'h000;
        end else if (begin_i) begin
            ch_q <= channel_i;
            cnt_q <= {1'h0, dly_i} + 5'h01;
            data_o <= ~data_o;
        end else if (cnt_q == 5'h01) begin
            cnt_q <= 5'h00;
            end_o <= 1'h1;
            hold_q <= 2'h2;
            data_o <= {8'hC5, ch_q};
        end else begin
            if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
            end
            if (end_o && hold_q != 2'h0) begin
                hold_q <= hold_q - 2'h1;
            end else begin
                end_o <= 1'h0;
                data_o <= ~data_o;
            end
        end
    end
endmodule
`default_nettype wire

/* test/acs_top_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
`include "acs_defs.svh"
module acs_top_checker #(
    parameter logic [7:0] ACLK_DIV = 8'h04
) (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    // register bus
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic S_AXI_RVALID_O,
    // converter side
    input wire logic CONV_BEGIN_O,
    input wire logic [3:0] CONV_CHANNEL_O,
    input wire logic CONV_END_I,
    input wire logic CONV_DONE_O,
    input wire logic BUSY_O
);
    logic wr_take;
    logic start_wr;
    logic start_ok;
    logic [6:0] mode_q;
    assign wr_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    assign start_wr = wr_take && S_AXI_AWADDR_I == `ACS_CTRL_OFS && S_AXI_WDATA_I[0] && !BUSY_O;
    assign start_ok = mode_q[0] && (mode_q[2:1] == 2'h1 || mode_q[6:1] == 6'h00);
    // mirror of the mode word, enough to know whether a start acts
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            mode_q <= 7'h00;
        end else if (wr_take && S_AXI_AWADDR_I == `ACS_MODE_OFS && S_AXI_WSTRB_I[0]) begin
            mode_q <= S_AXI_WDATA_I[6:0];
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);
    chk_start_latency: assert property (start_wr && start_ok |-> ##[6:16] CONV_BEGIN_O)
        else $error("no begin pulse after start write");
    chk_start_refused: assert property (start_wr && !mode_q[0] |=> ##4 !CONV_BEGIN_O[*8])
        else $error("begin pulse while converter disabled");
    chk_begin_spacing: assert property (CONV_BEGIN_O |=> !CONV_BEGIN_O[*7])
        else $error("begin pulses too close");
    chk_begin_busy: assert property (CONV_BEGIN_O |-> BUSY_O)
        else $error("begin pulse while idle");
    chk_channel_hold: assert property (CONV_BEGIN_O |=> $stable(CONV_CHANNEL_O)[*3])
        else $error("channel moved during conversion");
    chk_done_latency: assert property ($rose(CONV_END_I) && !CONV_DONE_O |-> ##[6:16] CONV_DONE_O)
        else $error("done flag late");
    chk_done_early: assert property ($rose(CONV_END_I) |=> !$rose(CONV_DONE_O)[*5])
        else $error("done flag early");
    chk_done_clear: assert property (wr_take && S_AXI_AWADDR_I == `ACS_STAT_OFS &&
        S_AXI_WDATA_I[0] && !BUSY_O && !CONV_END_I |-> ##2 !CONV_DONE_O)
        else $error("done flag not cleared");
    chk_write_resp: assert property (wr_take |=> S_AXI_BVALID_O)
        else $error("write response missing");
    chk_read_resp: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |-> ##2 S_AXI_RVALID_O)
        else $error("read response missing");
    cover property (CONV_BEGIN_O);
    cover property ($rose(CONV_DONE_O));
    cover property (start_wr && !mode_q[0]);
endmodule
bind acs_top acs_top_checker #(.ACLK_DIV(ACLK_DIV)) u_chk (.REF_CLK_I, .NRST_I,
    .S_AXI_AWADDR_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I,
    .S_AXI_BVALID_O, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RVALID_O, .CONV_BEGIN_O,
    .CONV_CHANNEL_O, .CONV_END_I, .CONV_DONE_O, .BUSY_O);
`default_nettype wire

/* test/acs_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "acs_defs.svh"
module acs_top_test;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [15:0] trig = 16'h0000;
    logic [3:0] dly = 4'h2;
    logic awready, wready, bvalid, arready, rvalid, cbeg, cend, done, busy;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    logic [3:0] chan;
    logic [11:0] cdata;
    logic [3:0] seen_ch[$];
    int errors = 0;
    int tests_run = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        if (cbeg === 1'h1) begin
            seen_ch.push_back(chan);
        end
    end
    acs_top u_dut (.REF_CLK_I(clk), .NRST_I(rst_n), .CE_I(1'h1),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .TIMER_TRIG_I(trig[7:0]),
        .PWM_TRIG_I(trig[15:8]), .CONV_BEGIN_O(cbeg), .CONV_CHANNEL_O(chan),
        .CONV_END_I(cend), .CONV_DATA_I(cdata), .CONV_DONE_O(done), .BUSY_O(busy));
    acs_conv_model u_conv (.clk_i(clk), .rst_n_i(rst_n), .begin_i(cbeg), .channel_i(chan),
        .dly_i(dly), .end_o(cend), .data_o(cdata));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // sampled at the falling edge, where outputs have settled
    task automatic await(ref logic sig, input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (sig !== lvl && n < 600);
        if (sig !== lvl) begin
            check("wait", {31'h0, sig}, {31'h0, lvl});
            stop_test();
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        await(awready, 1'h1);
        check("wready", {31'h0, wready}, 32'h0000_0001);
        @(posedge clk);
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        await(bvalid, 1'h1);
        r = bresp;
        @(posedge clk);
        bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        await(arready, 1'h1);
        @(posedge clk);
        arvalid <= 1'h0;
        await(rvalid, 1'h1);
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        check("bresp", {30'h0, r}, 32'h0000_0000);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        check(nm, d, exp);
    endtask
    task automatic fire(input logic [15:0] v);
        @(posedge clk);
        trig <= v;
        @(posedge clk);
        trig <= 16'h0000;
    endtask
    // zero means a software start
    task automatic run(input logic [15:0] v);
        wr(`ACS_STAT_OFS, 32'h0000_0001);
        if (v == 16'h0000) begin
            wr(`ACS_CTRL_OFS, 32'h0000_0001);
        end else begin
            fire(v);
        end
        await(done, 1'h1);
        await(busy, 1'h0);
    endtask
    // slot k is wired to channel 7-k by the channel word below
    task automatic conv_chk(input int n);
        logic [3:0] c;
        check("conversions", 32'(seen_ch.size()), 32'(n));
        for (int k = 0; k < n; k++) begin
            c = 4'(7 - k);
            check("channel", {28'h0, seen_ch.pop_front()}, {28'h0, c});
            rd_chk("result", `ACS_RES_OFS + 8'(4 * k), {16'h0, 8'hC5, c, 4'h0});
        end
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        rd_chk("mode", `ACS_MODE_OFS, 32'h0000_0000);
        rd_chk("trig", `ACS_TRIG_OFS, `ACS_TRIG_RST);
        rd_chk("chan", `ACS_CHAN_OFS, `ACS_CHAN_RST);
        axi_rd(8'h1C, rd, rsp);
        check("unmapped rresp", {30'h0, rsp}, 32'h0000_0002);
        axi_wr(`ACS_RES_OFS, 32'h0000_FFFF, rsp);
        check("result bresp", {30'h0, rsp}, 32'h0000_0002);
        $display("reset test ended");
        wr(`ACS_CHAN_OFS, 32'h0123_4567);
        wr(`ACS_CTRL_OFS, 32'h0000_0001);
        repeat (24) @(posedge clk);
        check("disabled begins", 32'(seen_ch.size()), 32'h0000_0000);
        rd_chk("start bit", `ACS_CTRL_OFS, 32'h0000_0000);
        $display("disabled test ended");
        wr(`ACS_MODE_OFS, 32'h0000_0001);
        run(16'h0000);
        conv_chk(1);
        axi_rd(`ACS_STAT_OFS, rd, rsp);
        check("done set", rd, 32'h0000_0001);
        wr(`ACS_STAT_OFS, 32'h0000_0001);
        axi_rd(`ACS_STAT_OFS, rd, rsp);
        check("done clear", rd, 32'h0000_0000);
        $display("single test ended");
        wr(`ACS_MODE_OFS, 32'h0000_0073);
        run(16'h0000);
        conv_chk(8);
        $display("burst start test ended");
        wr(`ACS_MODE_OFS, 32'h0000_0113);
        wr(`ACS_TRIG_OFS, 32'h0000_0005);
        fire(16'h0010);
        repeat (24) @(posedge clk);
        check("wrong timer", 32'(seen_ch.size()), 32'h0000_0000);
        run(16'h0020);
        conv_chk(2);
        dly <= 4'hF;
        wr(`ACS_MODE_OFS, 32'h0000_0203);
        wr(`ACS_TRIG_OFS, 32'h0000_0007);
        run(16'h8000);
        conv_chk(1);
        dly <= 4'h2;
        $display("burst trigger test ended");
        wr(`ACS_MODE_OFS, 32'h0000_0111);
        wr(`ACS_TRIG_OFS, 32'h0000_0032);
        wr(`ACS_STAT_OFS, 32'h0000_0001);
        wr(`ACS_CTRL_OFS, 32'h0000_0001);
        fire(16'h0008);
        repeat (24) @(posedge clk);
        check("slot order", 32'(seen_ch.size()), 32'h0000_0000);
        fire(16'h0004);
        await(done, 1'h1);
        check("first slot", 32'(seen_ch.size()), 32'h0000_0001);
        wr(`ACS_STAT_OFS, 32'h0000_0001);
        fire(16'h0008);
        await(done, 1'h1);
        await(busy, 1'h0);
        conv_chk(2);
        $display("sequential test ended");
        stop_test();
    end
endmodule
`default_nettype wire
